// ---- inc/pfp_pkg.sv ----
// Constants for the pin function and shared I/O port configuration block.
// Assumes an 8-bit register port with 7-bit addresses driven by the serial interface logic.
package pfp_pkg;

	// Register offsets.
	localparam logic [6:0] ADDR_PIN_TWO_CONFIG = 7'h0D;
	localparam logic [6:0] ADDR_IO_PORT_CONTROL = 7'h0E;

	// Fields of the third pin's configuration register.
	localparam int DRIVE_MSB = 7;
	localparam int DRIVE_LSB = 6;
	localparam int PULLUP_BIT = 5;
	localparam int FUNCTION_MSB = 4;
	localparam int FUNCTION_LSB = 0;

	// Fields of the I/O port control register.
	localparam int INT_STATUS_LSB = 4;
	localparam int IRQ_ON_SDO_BIT = 3;
	localparam int DIRECT_IO_LSB = 0;

	// Reset values.
	localparam logic [7:0] PIN_TWO_CONFIG_RESET = 8'h00;
	localparam logic [7:0] IO_PORT_CONTROL_RESET = 8'h00;

	localparam int PIN_COUNT = 3;

	// Pin function codes.
	localparam logic [4:0] FN_SPECIAL = 5'h00;
	localparam logic [4:0] FN_WAKEUP = 5'h01;
	localparam logic [4:0] FN_LOW_BATTERY = 5'h02;
	localparam logic [4:0] FN_DIRECT_IN = 5'h03;
	localparam logic [4:0] FN_INT_FALL = 5'h04;
	localparam logic [4:0] FN_INT_RISE = 5'h05;
	localparam logic [4:0] FN_INT_CHANGE = 5'h06;
	localparam logic [4:0] FN_ADC_INPUT = 5'h07;
	localparam logic [4:0] FN_TEST_N_IN = 5'h08;
	localparam logic [4:0] FN_TEST_P_IN = 5'h09;
	localparam logic [4:0] FN_DIRECT_OUT = 5'h0A;
	localparam logic [4:0] FN_DATA_CLOCK = 5'h0F;
	localparam logic [4:0] FN_TX_DATA_IN = 5'h10;
	localparam logic [4:0] FN_RETX_REQUEST = 5'h11;
	localparam logic [4:0] FN_TX_STATE = 5'h12;
	localparam logic [4:0] FN_TX_FIFO_FULL = 5'h13;
	localparam logic [4:0] FN_RX_DATA = 5'h14;
	localparam logic [4:0] FN_RX_STATE = 5'h15;
	localparam logic [4:0] FN_RX_FIFO_FULL = 5'h16;
	localparam logic [4:0] FN_ANTENNA_ONE = 5'h17;
	localparam logic [4:0] FN_ANTENNA_TWO = 5'h18;
	localparam logic [4:0] FN_PREAMBLE_VALID = 5'h19;
	localparam logic [4:0] FN_PREAMBLE_INVALID = 5'h1A;
	localparam logic [4:0] FN_SYNC_WORD = 5'h1B;
	localparam logic [4:0] FN_CLEAR_CHANNEL = 5'h1C;
	localparam logic [4:0] FN_SUPPLY_HIGH = 5'h1D;

endpackage

// ---- design/pfp_port_config.sv ----
// Function select, direct I/O, pull-up, drive strength and external interrupt status for three pins.
// Assumes the serial interface turns host transfers into single-cycle register strobes on mclk,
// and that the first two pins' function codes come from their own configuration registers elsewhere.
// Pull-ups and drive settings of the first two pins sit with those registers, not here.
//
// What this block does
// - Pull-up on third pin when enabled and pin is a digital input.
// - Bits 7:6 of third pin's configuration choose its drive strength.
// - Function code zero drives the controller clock out on the third pin.
// - Low battery code drives pin high while supply is below threshold.
// - Direct input code reads pin via direct bit; direct output drives from it.
// - Three codes make the pin an interrupt on falling, rising or any edge.
// - ADC code routes the pin to the converter and disables its driver.
// - Transmit data code on the third pin takes it as the direct modulation bit source.
// - Transmit state code drives the pin while the radio transmits.
// - Antenna one code drives the diversity select for antenna one.
// - Preamble and sync codes output their detected indications.
// - Bits 6, 5, 4 report interrupt status of pins two, one, zero.
// - With the data-out bit set, the interrupt request shows on data-out while select is high.
// - Writing a direct bit sets the level of a pin in direct output.
// - Reading a direct bit returns the sampled level of a pin in direct input.

`timescale 1ns/1ps

module pfp_port_config (
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst_n,
	// Register port.
	input wire logic [6:0] regAddr,
	input wire logic regWrite,
	input wire logic [7:0] regWrData,
	input wire logic regRead,
	output logic [7:0] regRdData,
	// Function codes of the first two pins.
	input wire logic [4:0] pinZeroFunction,
	input wire logic [4:0] pinOneFunction,
	// Level each of the first two pins shows for codes zero and one.
	input wire logic [1:0] pinSpecialLevel,
	input wire logic [1:0] pinWakeupLevel,
	// Internal status sources.
	input wire logic mcuClock,
	input wire logic lowBattery,
	input wire logic dataClock,
	input wire logic txState,
	input wire logic txFifoAlmostFull,
	input wire logic rxData,
	input wire logic rxState,
	input wire logic rxFifoAlmostFull,
	input wire logic antennaOneSelect,
	input wire logic antennaTwoSelect,
	input wire logic preambleValid,
	input wire logic preambleInvalid,
	input wire logic syncWordDetected,
	input wire logic clearChannel,
	input wire logic interrupt_request_n,
	// General pins, split into input, output and output enable.
	input wire logic [2:0] generalPinIn,
	output logic [2:0] generalPinOut,
	output logic [2:0] generalPinOe,
	// Pad controls of the third pin.
	output logic pinTwoPullupOn,
	output logic [1:0] pinTwoDriveStrength,
	// Analog routing and direct modulation.
	output logic [2:0] adcRouteEnable,
	output logic txDirectData,
	output logic retxRequest,
	// External interrupt events to the interrupt controller.
	output logic [2:0] extIntEvent,
	// Chip select pin and data-out override.
	input wire logic chip_select_n,
	output logic sdoIrqSelect,
	output logic sdoIrqLevel
);

	// Every code that listens to the pin, the reserved analog test inputs included.
	function automatic logic isInputCode(input logic [4:0] code);
		isInputCode = (code == pfp_pkg::FN_DIRECT_IN) || (code == pfp_pkg::FN_INT_FALL) ||
			(code == pfp_pkg::FN_INT_RISE) || (code == pfp_pkg::FN_INT_CHANGE) ||
			(code == pfp_pkg::FN_ADC_INPUT) || (code == pfp_pkg::FN_TEST_N_IN) ||
			(code == pfp_pkg::FN_TEST_P_IN) || (code == pfp_pkg::FN_TX_DATA_IN) ||
			(code == pfp_pkg::FN_RETX_REQUEST);
	endfunction

	// Analog and test inputs must never see the pull-up, so they are left out here.
	function automatic logic isDigitalInputCode(input logic [4:0] code);
		isDigitalInputCode = isInputCode(code) && (code != pfp_pkg::FN_ADC_INPUT) &&
			(code != pfp_pkg::FN_TEST_N_IN) && (code != pfp_pkg::FN_TEST_P_IN);
	endfunction

	function automatic logic isInterruptCode(input logic [4:0] code);
		isInterruptCode = (code == pfp_pkg::FN_INT_FALL) || (code == pfp_pkg::FN_INT_RISE) ||
			(code == pfp_pkg::FN_INT_CHANGE);
	endfunction

	// Configuration registers.
	logic [1:0] pin_two_drive_strength;
	logic pin_two_pullup_enable;
	logic [4:0] pin_two_function_select;
	logic irqOnDataOut;
	logic [2:0] directOutBits;
	logic [2:0] intStatus;
	logic [7:0] next_regRdData;
	logic [1:0] next_pin_two_drive_strength;
	logic next_pin_two_pullup_enable;
	logic [4:0] next_pin_two_function_select;
	logic next_irqOnDataOut;
	logic [2:0] next_directOutBits;
	logic [2:0] next_intStatus;

	// Pin sampling.
	logic [2:0] pinMeta;
	logic [2:0] pinSync;
	logic [2:0] pinPrev;
	logic selectMeta;
	logic selectSync;
	// Synchroniser next values.
	logic [2:0] next_pinMeta;
	logic [2:0] next_pinSync;
	logic [2:0] next_pinPrev;
	logic next_selectMeta;
	logic next_selectSync;

	// Per-pin decoded function and drive.
	logic [4:0] pinFunction [2:0];
	logic [2:0] pinInput;
	logic [2:0] pinEdgeHit;
	logic [2:0] intSource;
	logic [2:0] next_generalPinOut;
	logic [2:0] next_generalPinOe;
	logic [2:0] next_adcRouteEnable;
	logic [2:0] next_extIntEvent;
	logic next_pinTwoPullupOn;
	logic next_txDirectData;
	logic next_retxRequest;
	logic next_sdoIrqSelect;
	logic next_sdoIrqLevel;
	logic [1:0] next_pinTwoDriveStrength;
	logic [2:0] directIoView;
	logic [2:0] specialLevel;
	logic [2:0] wakeupLevel;

	assign pinFunction[0] = pinZeroFunction;
	assign pinFunction[1] = pinOneFunction;
	assign pinFunction[2] = pin_two_function_select;
	// Code zero shows a level made elsewhere on the first two pins and the controller clock on the third.
	assign specialLevel = {mcuClock, pinSpecialLevel};
	// The third pin has no wake-up function, so that code grounds it.
	assign wakeupLevel = {1'b0, pinWakeupLevel};

	// Pins and chip select arrive from off-chip, so two stages before any use.
	// The third stage only remembers the previous synchronised level for edge detection.
	always_comb begin
		next_pinMeta = generalPinIn;
		next_pinSync = pinMeta;
		next_pinPrev = pinSync;
		next_selectMeta = chip_select_n;
		next_selectSync = selectMeta;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pinMeta <= 3'h0;
			pinSync <= 3'h0;
			pinPrev <= 3'h0;
			// Select resets to its idle level, matching a host that is not talking.
			selectMeta <= 1'b1;
			selectSync <= 1'b1;
		end else begin
			pinMeta <= next_pinMeta;
			pinSync <= next_pinSync;
			pinPrev <= next_pinPrev;
			selectMeta <= next_selectMeta;
			selectSync <= next_selectSync;
		end
	end

	// Each pin gets the same decode; only its function code and sources differ.
	genvar gi;
	generate
		for (gi = 0; gi < pfp_pkg::PIN_COUNT; gi++) begin : gPin
			logic outLevel;
			assign pinInput[gi] = isInputCode(pinFunction[gi]);
			assign intSource[gi] = isInterruptCode(pinFunction[gi]);

			// Edges come from the synchronised pin, never from the raw input.
			always_comb begin
				unique case (pinFunction[gi])
					pfp_pkg::FN_INT_FALL: pinEdgeHit[gi] = pinPrev[gi] & ~pinSync[gi];
					pfp_pkg::FN_INT_RISE: pinEdgeHit[gi] = ~pinPrev[gi] & pinSync[gi];
					pfp_pkg::FN_INT_CHANGE: pinEdgeHit[gi] = pinPrev[gi] ^ pinSync[gi];
					default: pinEdgeHit[gi] = 1'b0;
				endcase
			end

			// Reserved and unlisted output codes fall through to ground.
			always_comb begin
				unique case (pinFunction[gi])
					pfp_pkg::FN_SPECIAL: outLevel = specialLevel[gi];
					pfp_pkg::FN_WAKEUP: outLevel = wakeupLevel[gi];
					pfp_pkg::FN_LOW_BATTERY: outLevel = lowBattery;
					pfp_pkg::FN_DIRECT_OUT: outLevel = directOutBits[gi];
					pfp_pkg::FN_DATA_CLOCK: outLevel = dataClock;
					pfp_pkg::FN_TX_STATE: outLevel = txState;
					pfp_pkg::FN_TX_FIFO_FULL: outLevel = txFifoAlmostFull;
					pfp_pkg::FN_RX_DATA: outLevel = rxData;
					pfp_pkg::FN_RX_STATE: outLevel = rxState;
					pfp_pkg::FN_RX_FIFO_FULL: outLevel = rxFifoAlmostFull;
					pfp_pkg::FN_ANTENNA_ONE: outLevel = antennaOneSelect;
					pfp_pkg::FN_ANTENNA_TWO: outLevel = antennaTwoSelect;
					pfp_pkg::FN_PREAMBLE_VALID: outLevel = preambleValid;
					pfp_pkg::FN_PREAMBLE_INVALID: outLevel = preambleInvalid;
					pfp_pkg::FN_SYNC_WORD: outLevel = syncWordDetected;
					pfp_pkg::FN_CLEAR_CHANNEL: outLevel = clearChannel;
					pfp_pkg::FN_SUPPLY_HIGH: outLevel = 1'b1;
					default: outLevel = 1'b0;
				endcase
			end

			// An input keeps its driver off and its level low, so nothing fights the outside source.
			assign next_generalPinOut[gi] = pinInput[gi] ? 1'b0 : outLevel;
			assign next_generalPinOe[gi] = ~pinInput[gi];
			assign next_adcRouteEnable[gi] = (pinFunction[gi] == pfp_pkg::FN_ADC_INPUT);
			// Events reach the interrupt controller whether or not the status has been read.
			assign next_extIntEvent[gi] = pinEdgeHit[gi];
			// A direct input shows the sampled pin; otherwise the written bit reads back.
			assign directIoView[gi] = (pinFunction[gi] == pfp_pkg::FN_DIRECT_IN) ?
				pinSync[gi] : directOutBits[gi];
		end
	endgenerate

	// Register file: writes, reads, and interrupt status that clears on read.
	always_comb begin
		next_pin_two_drive_strength = pin_two_drive_strength;
		next_pin_two_pullup_enable = pin_two_pullup_enable;
		next_pin_two_function_select = pin_two_function_select;
		next_irqOnDataOut = irqOnDataOut;
		next_directOutBits = directOutBits;
		next_intStatus = intStatus;
		// Read data holds between reads so the serial logic may collect it late.
		next_regRdData = regRdData;
		if (regRead) begin
			unique case (regAddr)
				pfp_pkg::ADDR_PIN_TWO_CONFIG: begin
					next_regRdData = {pin_two_drive_strength, pin_two_pullup_enable, pin_two_function_select};
				end
				pfp_pkg::ADDR_IO_PORT_CONTROL: begin
					// Bit 7 is reserved and always reads zero.
					next_regRdData = {1'b0, intStatus, irqOnDataOut, directIoView};
					next_intStatus = 3'h0;
				end
				default: begin
					// Unmapped addresses read as zero.
					next_regRdData = 8'h00;
				end
			endcase
		end
		if (regWrite) begin
			unique case (regAddr)
				pfp_pkg::ADDR_PIN_TWO_CONFIG: begin
					next_pin_two_drive_strength = regWrData[pfp_pkg::DRIVE_MSB:pfp_pkg::DRIVE_LSB];
					next_pin_two_pullup_enable = regWrData[pfp_pkg::PULLUP_BIT];
					next_pin_two_function_select = regWrData[pfp_pkg::FUNCTION_MSB:pfp_pkg::FUNCTION_LSB];
				end
				pfp_pkg::ADDR_IO_PORT_CONTROL: begin
					next_irqOnDataOut = regWrData[pfp_pkg::IRQ_ON_SDO_BIT];
					next_directOutBits = regWrData[pfp_pkg::DIRECT_IO_LSB +: 3];
				end
				default: begin
					// Writes elsewhere, and to the read-only status bits, are ignored.
				end
			endcase
		end
		// An edge in the same cycle as the clearing read is kept.
		for (int i = 0; i < pfp_pkg::PIN_COUNT; i++) begin
			if (pinEdgeHit[i] && intSource[i]) begin
				next_intStatus[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pin_two_drive_strength <= pfp_pkg::PIN_TWO_CONFIG_RESET[pfp_pkg::DRIVE_MSB:pfp_pkg::DRIVE_LSB];
			pin_two_pullup_enable <= pfp_pkg::PIN_TWO_CONFIG_RESET[pfp_pkg::PULLUP_BIT];
			pin_two_function_select <= pfp_pkg::PIN_TWO_CONFIG_RESET[pfp_pkg::FUNCTION_MSB:pfp_pkg::FUNCTION_LSB];
			irqOnDataOut <= pfp_pkg::IO_PORT_CONTROL_RESET[pfp_pkg::IRQ_ON_SDO_BIT];
			directOutBits <= pfp_pkg::IO_PORT_CONTROL_RESET[pfp_pkg::DIRECT_IO_LSB +: 3];
			intStatus <= pfp_pkg::IO_PORT_CONTROL_RESET[pfp_pkg::INT_STATUS_LSB +: 3];
			regRdData <= 8'h00;
		end else begin
			pin_two_drive_strength <= next_pin_two_drive_strength;
			pin_two_pullup_enable <= next_pin_two_pullup_enable;
			pin_two_function_select <= next_pin_two_function_select;
			irqOnDataOut <= next_irqOnDataOut;
			directOutBits <= next_directOutBits;
			intStatus <= next_intStatus;
			regRdData <= next_regRdData;
		end
	end

	// Pad and routing outputs.
	always_comb begin
		next_pinTwoPullupOn = pin_two_pullup_enable && isDigitalInputCode(pin_two_function_select);
		// Drive strength only goes to the pad; no logic here depends on it.
		next_pinTwoDriveStrength = pin_two_drive_strength;
		// Transmit data and retransmit requests follow the synchronised pin, a few cycles behind it.
		next_txDirectData = (pin_two_function_select == pfp_pkg::FN_TX_DATA_IN) && pinSync[2];
		next_retxRequest = (pin_two_function_select == pfp_pkg::FN_RETX_REQUEST) && pinSync[2];
		// The override is only safe while the host is not clocking data out.
		next_sdoIrqSelect = irqOnDataOut && selectSync;
		next_sdoIrqLevel = next_sdoIrqSelect ? interrupt_request_n : 1'b1;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			generalPinOut <= 3'h0;
			generalPinOe <= 3'h0;
			adcRouteEnable <= 3'h0;
			extIntEvent <= 3'h0;
			pinTwoDriveStrength <= 2'h0;
			pinTwoPullupOn <= 1'b0;
			txDirectData <= 1'b0;
			retxRequest <= 1'b0;
			sdoIrqSelect <= 1'b0;
			// The data-out level idles high, the released state of an active-low request.
			sdoIrqLevel <= 1'b1;
		end else begin
			generalPinOut <= next_generalPinOut;
			generalPinOe <= next_generalPinOe;
			adcRouteEnable <= next_adcRouteEnable;
			extIntEvent <= next_extIntEvent;
			pinTwoDriveStrength <= next_pinTwoDriveStrength;
			pinTwoPullupOn <= next_pinTwoPullupOn;
			txDirectData <= next_txDirectData;
			retxRequest <= next_retxRequest;
			sdoIrqSelect <= next_sdoIrqSelect;
			sdoIrqLevel <= next_sdoIrqLevel;
		end
	end

endmodule

// ---- testbench/pfp_port_config_chk.sv ----
// Timing checks on the port block's pins and register port.
// Assumes it is bound to pfp_port_config and sees only its ports.
`timescale 1ns/1ps
module pfp_port_config_chk (
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst_n,
	// Register port.
	input wire logic [6:0] regAddr,
	input wire logic regWrite,
	input wire logic [7:0] regWrData,
	input wire logic regRead,
	input wire logic [7:0] regRdData,
	// Sources and pins.
	input wire logic [4:0] pinZeroFunction,
	input wire logic lowBattery,
	input wire logic interrupt_request_n,
	input wire logic chip_select_n,
	input wire logic [2:0] generalPinIn,
	input wire logic [2:0] generalPinOut,
	input wire logic [2:0] generalPinOe,
	input wire logic pinTwoPullupOn,
	input wire logic [1:0] pinTwoDriveStrength,
	input wire logic [2:0] adcRouteEnable,
	input wire logic [2:0] extIntEvent,
	input wire logic sdoIrqSelect,
	input wire logic sdoIrqLevel
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic cfgWr;
	logic portRd;
	logic [1:0] wrDrive;
	logic pinTwo;
	logic zeroIn;
	logic zeroBattery;
	assign cfgWr = regWrite && regAddr == pfp_pkg::ADDR_PIN_TWO_CONFIG;
	assign portRd = regRead && regAddr == pfp_pkg::ADDR_IO_PORT_CONTROL;
	assign wrDrive = regWrData[7:6];
	assign pinTwo = generalPinIn[2];
	// Codes for which the first pin must leave its driver off.
	assign zeroIn = pinZeroFunction inside {[5'h03:5'h09], 5'h10, 5'h11};
	assign zeroBattery = pinZeroFunction == pfp_pkg::FN_LOW_BATTERY;
	a_drive_field: assert property (cfgWr ##1 !cfgWr |=> pinTwoDriveStrength == $past(wrDrive, 2))
		else $error("drive strength differs from written field");
	a_pullup_input: assert property (pinTwoPullupOn |-> !generalPinOe[2])
		else $error("pull-up on while pin is driven");
	a_input_undriven: assert property ($past(zeroIn) |-> !generalPinOe[0])
		else $error("input pin driven");
	a_adc_route: assert property (adcRouteEnable[0] == ($past(pinZeroFunction) == pfp_pkg::FN_ADC_INPUT))
		else $error("converter route wrong");
	a_low_battery: assert property ($past(zeroBattery) |-> generalPinOe[0] && generalPinOut[0] == $past(lowBattery))
		else $error("battery flag not on pin");
	a_event_edge: assert property (extIntEvent[2] |-> $past(pinTwo, 3) != $past(pinTwo, 4))
		else $error("event without pin edge");
	a_status_clear: assert property (portRd ##1 (portRd && extIntEvent == 3'h0) |=> regRdData[6:4] == 3'h0)
		else $error("status not cleared by read");
	a_sdo_level: assert property (sdoIrqLevel == (sdoIrqSelect ? $past(interrupt_request_n) : 1'b1))
		else $error("data-out request level wrong");
	a_sdo_select: assert property (!chip_select_n [*5] |=> !sdoIrqSelect)
		else $error("request on data-out while selected");
endmodule
bind pfp_port_config pfp_port_config_chk u_chk (.mclk, .rst_n, .regAddr, .regWrite, .regWrData, .regRead, .regRdData,
	.pinZeroFunction, .lowBattery, .interrupt_request_n, .chip_select_n, .generalPinIn, .generalPinOut, .generalPinOe,
	.pinTwoPullupOn, .pinTwoDriveStrength, .adcRouteEnable, .extIntEvent, .sdoIrqSelect, .sdoIrqLevel);

// ---- testbench/pfp_board_model.sv ----
// Board model resolving the three general pins.
// Where the bench and the block both drive a pin, the block's driver wins.
`timescale 1ns/1ps
module pfp_board_model (
	// Clock.
	input wire logic mclk,
	// Block side.
	input wire logic [2:0] generalPinOut,
	input wire logic [2:0] generalPinOe,
	input wire logic pinTwoPullupOn,
	// Bench side.
	input wire logic [2:0] extDrive,
	input wire logic [2:0] extLevel,
	output logic [2:0] generalPinIn
);
	// A floating pin toggles so that a stale level never passes for a driven one.
	logic floatLevel = 1'b0;
	always @(negedge mclk) floatLevel <= ~floatLevel;
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			if (generalPinOe[i])
				generalPinIn[i] = generalPinOut[i];
			else if (extDrive[i])
				generalPinIn[i] = extLevel[i];
			else if (i == 2 && pinTwoPullupOn)
				generalPinIn[i] = 1'b1;
			else
				generalPinIn[i] = floatLevel;
		end
	end
endmodule

// ---- testbench/pfp_port_config_tb_top.sv ----
// Self-checking bench for the port block, driving inputs at the falling edge.
// Assumes the checker is bound in and the board model stands on the pins.
`timescale 1ns/1ps
module pfp_port_config_tb_top;
	localparam logic [6:0] CFG = pfp_pkg::ADDR_PIN_TWO_CONFIG;
	localparam logic [6:0] PRT = pfp_pkg::ADDR_IO_PORT_CONTROL;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [6:0] regAddr = 7'h00;
	logic regWrite = 1'b0;
	logic [7:0] regWrData = 8'h00;
	logic regRead = 1'b0;
	logic [7:0] regRdData;
	logic [4:0] pinZeroFunction = pfp_pkg::FN_DIRECT_IN;
	logic [4:0] pinOneFunction = pfp_pkg::FN_DIRECT_OUT;
	logic [1:0] pinSpecialLevel = 2'h0;
	logic [1:0] pinWakeupLevel = 2'h0;
	logic [13:0] src = 14'h0000;
	logic interrupt_request_n = 1'b1;
	logic chip_select_n = 1'b0;
	logic [2:0] extDrive = 3'h0;
	logic [2:0] extLevel = 3'h0;
	logic [2:0] generalPinIn, generalPinOut, generalPinOe, adcRouteEnable, extIntEvent;
	logic [1:0] pinTwoDriveStrength;
	logic pinTwoPullupOn, txDirectData, retxRequest, sdoIrqSelect, sdoIrqLevel;
	logic [7:0] d0, d1;
	logic [4:0] code;
	int err_total = 0;
	int checks_done = 0;
	int cycles = 0;
	initial forever #5 mclk = ~mclk;
	pfp_port_config u_pfp_port_config (.mclk, .rst_n, .regAddr, .regWrite, .regWrData, .regRead, .regRdData,
		.pinZeroFunction, .pinOneFunction, .pinSpecialLevel, .pinWakeupLevel, .mcuClock(src[0]), .lowBattery(src[1]),
		.dataClock(src[2]), .txState(src[3]), .txFifoAlmostFull(src[4]), .rxData(src[5]), .rxState(src[6]),
		.rxFifoAlmostFull(src[7]), .antennaOneSelect(src[8]), .antennaTwoSelect(src[9]), .preambleValid(src[10]),
		.preambleInvalid(src[11]), .syncWordDetected(src[12]), .clearChannel(src[13]), .interrupt_request_n,
		.generalPinIn, .generalPinOut, .generalPinOe, .pinTwoPullupOn, .pinTwoDriveStrength, .adcRouteEnable,
		.txDirectData, .retxRequest, .extIntEvent, .chip_select_n, .sdoIrqSelect, .sdoIrqLevel);
	pfp_board_model u_pfp_board_model (.mclk, .generalPinOut, .generalPinOe, .pinTwoPullupOn, .extDrive, .extLevel,
		.generalPinIn);
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			complete_run();
		end
	end
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge mclk);
		regAddr = a;
		regWrData = d;
		regWrite = 1'b1;
		@(negedge mclk);
		regWrite = 1'b0;
	endtask
	task automatic rd(input logic [6:0] a, input bit twice);
		@(negedge mclk);
		regAddr = a;
		regRead = 1'b1;
		@(negedge mclk);
		d0 = regRdData;
		d1 = d0;
		if (twice) begin
			@(negedge mclk);
			d1 = regRdData;
		end
		regRead = 1'b0;
	endtask
	initial begin
		tick(8);
		rst_n = 1'b1;
		rd(CFG, 0);
		check("config reset", d0, pfp_pkg::PIN_TWO_CONFIG_RESET);
		rd(PRT, 0);
		check("port reset", d0 & 8'hFE, pfp_pkg::IO_PORT_CONTROL_RESET);
		wr(7'h0F, 8'hFF);
		rd(7'h0F, 0);
		check("unmapped", d0, 8'h00);
		$display("test registers done");
		wr(CFG, 8'hA3);
		rd(CFG, 0);
		check("config", d0, 8'hA3);
		check("drive", 8'(pinTwoDriveStrength), 8'h02);
		check("pullup", 8'({pinTwoPullupOn, generalPinOe[2]}), 8'h02);
		rd(PRT, 0);
		check("pin_two_direct_io pulled", 8'(d0[2]), 8'h01);
		extDrive = 3'h4;
		tick(3);
		rd(PRT, 0);
		check("pin_two_direct_io low", 8'(d0[2]), 8'h00);
		$display("test direct input done");
		// Only documented codes are written; the reserved test codes stay unused.
		pinZeroFunction = pfp_pkg::FN_LOW_BATTERY;
		for (int i = 0; i < 14; i++) begin
			code = (i == 0) ? 5'h00 : (i == 1) ? 5'h02 : (i == 2) ? 5'h0F : 5'(15 + i);
			wr(CFG, {3'h0, code});
			src = 14'h0001 << i;
			tick(2);
			check("source high", 8'({generalPinOe[2], generalPinOut[2]}), 8'h03);
			src = 14'h0000;
			tick(2);
			check("source low", 8'({generalPinOe[2], generalPinOut[2]}), 8'h02);
		end
		pinZeroFunction = pfp_pkg::FN_ADC_INPUT;
		wr(CFG, 8'h0A);
		wr(PRT, 8'h06);
		tick(2);
		check("direct out high", 8'({generalPinOe[2], generalPinOut[2]}), 8'h03);
		check("pin one out", 8'({generalPinOe[1], generalPinOut[1]}), 8'h03);
		check("adc pin zero", 8'(adcRouteEnable[0]), 8'h01);
		wr(PRT, 8'h00);
		tick(2);
		check("direct out low", 8'({generalPinOe[2], generalPinOut[2]}), 8'h02);
		pinZeroFunction = pfp_pkg::FN_DIRECT_IN;
		$display("test outputs done");
		extLevel = 3'h4;
		wr(CFG, 8'h10);
		tick(4);
		check("tx data", 8'({generalPinOe[2], txDirectData}), 8'h01);
		wr(CFG, 8'h11);
		tick(2);
		check("retx", 8'({generalPinOe[2], retxRequest}), 8'h01);
		wr(CFG, 8'h07);
		tick(2);
		check("adc pin two", 8'({generalPinOe[2], adcRouteEnable[2]}), 8'h01);
		for (int m = 0; m < 3; m++) begin
			extLevel = 3'h0;
			wr(CFG, 8'h04 + 8'(m));
			tick(5);
			rd(PRT, 1);
			extLevel = 3'h4;
			tick(5);
			rd(PRT, 1);
			check("rise status", 8'(d0[6]), 8'(m != 0));
			check("status cleared", 8'(d1[6]), 8'h00);
			extLevel = 3'h0;
			tick(5);
			rd(PRT, 0);
			check("fall status", 8'(d0[6]), 8'(m != 1));
		end
		pinZeroFunction = pfp_pkg::FN_INT_RISE;
		extDrive = 3'h5;
		tick(5);
		rd(PRT, 0);
		extLevel = 3'h1;
		tick(5);
		rd(PRT, 0);
		check("pin zero status", 8'(d0[4]), 8'h01);
		pinZeroFunction = pfp_pkg::FN_DIRECT_IN;
		$display("test interrupts done");
		extDrive = 3'h0;
		wr(PRT, 8'h08);
		chip_select_n = 1'b1;
		interrupt_request_n = 1'b0;
		tick(5);
		check("sdo request", 8'({sdoIrqSelect, sdoIrqLevel}), 8'h02);
		chip_select_n = 1'b0;
		tick(5);
		check("sdo released", 8'({sdoIrqSelect, sdoIrqLevel}), 8'h01);
		$display("test data-out done");
		complete_run();
	end
endmodule
